// *** hw/idc_pkg.sv ***
// Purpose : constants shared by the isochronous dma context register bank
// Assumes : 40 MHz i_clk, Avalon-MM byte addressing, 32-bit data

package idc_pkg;

  localparam int          NUM_CTX      = 8;
  localparam int          ADDR_W       = 11;

  // ===========================================================
  // register map (byte addresses)
  localparam logic [10:0] TX_PTR_BASE  = 11'h20c;
  localparam logic [10:0] TX_STRIDE    = 11'h010;
  localparam logic [10:0] RX_SET_BASE  = 11'h400;
  localparam logic [10:0] RX_CLR_BASE  = 11'h404;
  localparam logic [10:0] RX_STRIDE    = 11'h020;

  // ===========================================================
  // receive control field positions
  localparam int          B_PACK       = 31;
  localparam int          B_KEEP_HDR   = 30;
  localparam int          B_SOC_EN     = 29;
  localparam int          B_ALL_CHAN   = 28;
  localparam int          B_SPLIT      = 27;
  localparam int          B_RUN        = 15;
  localparam int          B_WAKE       = 12;
  localparam int          B_DEAD       = 11;
  localparam int          B_ACTIVE     = 10;
  localparam int          SPD_LSB      = 5;
  localparam int          CODE_LSB     = 0;

  // ===========================================================
  // reset values
  localparam logic [31:0] TX_PTR_RST   = 32'h0000_0000;
  localparam logic [4:0]  MODE_RST     = 5'h00;
  localparam logic [2:0]  SPD_RST      = 3'h0;
  localparam logic [4:0]  CODE_RST     = 5'h00;

  // ===========================================================
  // speed codes
  localparam logic [2:0]  SPD_100      = 3'h0;
  localparam logic [2:0]  SPD_200      = 3'h1;
  localparam logic [2:0]  SPD_400      = 3'h2;

endpackage

// *** hw/idc_ctx_if.sv ***
// Purpose : carries one receive context's strobes and state between bank and context
// Assumes : all signals on i_clk
// Notes   : reg_mp is the bank side, ctx_mp the context side
`timescale 1ns/1ps
`default_nettype none

interface idc_ctx_if;
  logic        set_we;
  logic        clr_we;
  logic [31:0] wdata;
  logic        fetch;
  logic        fatal;
  logic        active;
  logic        status_we;
  logic [2:0]  speed;
  logic [4:0]  code;
  logic        cyc_match;
  logic [31:0] ctrl;
  logic [4:0]  mode;
  logic        start_ok;

  modport reg_mp
  (
    output set_we, clr_we, wdata, fetch, fatal, active, status_we, speed, code, cyc_match,
    input  ctrl, mode, start_ok
  );
  modport ctx_mp
  (
    input  set_we, clr_we, wdata, fetch, fatal, active, status_we, speed, code, cyc_match,
    output ctrl, mode, start_ok
  );
endinterface

`default_nettype wire

// *** hw/idc_rx_ctx.sv ***
// Purpose : one isochronous receive context control register with set/clear access
// Assumes : strobes are one-cycle pulses on i_clk
// Notes   : hardware set wins over a software clear in the same cycle
`timescale 1ns/1ps
`default_nettype none

module idc_rx_ctx
(
  input  wire logic  i_clk,
  input  wire logic  i_srst,
  idc_ctx_if.ctx_mp  bus
);

  logic [4:0] mode_q;
  logic       run_q;
  logic       wake_q;
  logic       dead_q;
  logic       active_q;
  logic [2:0] spd_q;
  logic [4:0] code_q;
  logic       start_q;
  logic [4:0] mode_set;
  logic [4:0] mode_clr;
  logic       run_clr;

  assign mode_set = bus.set_we ? bus.wdata[idc_pkg::B_PACK -: 5] : 5'h00;
  assign mode_clr = bus.clr_we ? bus.wdata[idc_pkg::B_PACK -: 5] : 5'h00;
  assign run_clr  = bus.clr_we & bus.wdata[idc_pkg::B_RUN];

  // ===========================================================
  // mode bits; bit 2 of mode is start_on_cycle_enable
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      mode_q <= idc_pkg::MODE_RST;
    else
      mode_q <= ((mode_q & ~mode_clr) & ~{2'b00, active_q, 2'b00}) | mode_set;
  end

  // ===========================================================
  // run: only software or reset touches it
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      run_q <= 1'b0;
    else if (bus.set_we && bus.wdata[idc_pkg::B_RUN])
      run_q <= 1'b1;
    else if (run_clr)
      run_q <= 1'b0;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      wake_q <= 1'b0;
    else
      wake_q <= (bus.set_we & bus.wdata[idc_pkg::B_WAKE])
              | (wake_q & ~bus.fetch & ~(bus.clr_we & bus.wdata[idc_pkg::B_WAKE]));
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      dead_q <= 1'b0;
    else
      dead_q <= bus.fatal | (dead_q & ~(run_clr & run_q));
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      active_q <= 1'b0;
    else
      active_q <= bus.active;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      spd_q  <= idc_pkg::SPD_RST;
      code_q <= idc_pkg::CODE_RST;
    end
    else if (bus.status_we)
    begin
      spd_q  <= bus.speed;
      code_q <= bus.code;
    end
  end

  // start permission: a cycle-gated start waits for the cycle match
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      start_q <= 1'b0;
    else
      start_q <= run_q & ~dead_q & (~mode_q[2] | bus.cyc_match);
  end

  assign bus.mode     = mode_q;
  assign bus.start_ok = start_q;
  assign bus.ctrl     = {mode_q, 11'h000, run_q, 2'b00, wake_q, dead_q, active_q, 2'b00, spd_q, code_q};

endmodule

`default_nettype wire

// *** hw/idc_iso_dma_regs.sv ***
// Purpose : isochronous dma context register bank: tx pointers and rx control set/clear
// Assumes : Avalon-MM slave with waitrequest, byte addresses, single clock i_clk
// Notes   : every access stalls one cycle, then completes; unmapped reads return zero
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

module idc_iso_dma_regs
(
  input  wire logic              i_clk,
  input  wire logic              i_srst,
  // Avalon-MM slave
  input  wire logic [10:0]       i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  input  wire logic [3:0]        i_avs_byteenable,
  output logic      [31:0]       o_avs_readdata,
  output logic                   o_avs_waitrequest,
  // transmit fetch engine
  output logic      [7:0][27:0]  o_tx_desc_base,
  output logic      [7:0][3:0]   o_tx_desc_count,
  // receive engine, per context
  input  wire logic [7:0]        i_rx_fetch,
  input  wire logic [7:0]        i_rx_fatal,
  input  wire logic [7:0]        i_rx_active,
  input  wire logic [7:0]        i_rx_status_we,
  input  wire logic [7:0][2:0]   i_rx_speed,
  input  wire logic [7:0][4:0]   i_rx_code,
  input  wire logic [7:0][14:0]  i_start_cycle_value,
  input  wire logic [1:0]        i_seconds_count,
  input  wire logic [12:0]       i_cycle_number,
  output logic      [7:0]        o_rx_pack_buffer_mode,
  output logic      [7:0]        o_rx_keep_packet_header,
  output logic      [7:0]        o_rx_all_channel_mode,
  output logic      [7:0]        o_rx_split_payload_mode,
  output logic      [7:0]        o_rx_start_ok
);

  // ===========================================================
  // address decode helpers
  function automatic logic hit_tx(input logic [10:0] a, output logic [2:0] n);
    logic [10:0] off;
    off = a - idc_pkg::TX_PTR_BASE;
    n   = off[6:4];
    return (a >= idc_pkg::TX_PTR_BASE) && (off[3:0] == 4'h0)
           && (off < idc_pkg::TX_STRIDE * 11'd8);
  endfunction

  function automatic logic hit_rx(input logic [10:0] a, input logic [10:0] base, output logic [2:0] n);
    logic [10:0] off;
    off = a - base;
    n   = off[7:5];
    return (a >= base) && (off[4:0] == 5'h00) && (off < idc_pkg::RX_STRIDE * 11'd8);
  endfunction

  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (be[b])
        r[b*8 +: 8] = wd[b*8 +: 8];
    return r;
  endfunction

  // ===========================================================
  // bus handshake: first edge drops waitrequest, second edge completes
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        done;
  logic        tx_hit;
  logic        set_hit;
  logic        clr_hit;
  logic [2:0]  tx_n;
  logic [2:0]  set_n;
  logic [2:0]  clr_n;
  logic [31:0] rx_wd;

  assign done = (i_avs_read | i_avs_write) & ~wait_q;

  always_comb
  begin
    tx_hit  = hit_tx(i_avs_address, tx_n);
    set_hit = hit_rx(i_avs_address, idc_pkg::RX_SET_BASE, set_n);
    clr_hit = hit_rx(i_avs_address, idc_pkg::RX_CLR_BASE, clr_n);
  end

  // byte lanes not enabled contribute zeros, so they neither set nor clear
  assign rx_wd = merge_be(32'h0000_0000, i_avs_writedata, i_avs_byteenable);

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      wait_q <= 1'b1;
    else if (done)
      wait_q <= 1'b1;
    else if (i_avs_read | i_avs_write)
      wait_q <= 1'b0;
  end

  // ===========================================================
  // transmit descriptor pointers
  logic [7:0][31:0] tx_ptr_q;

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      tx_ptr_q <= {8{idc_pkg::TX_PTR_RST}};
    else if (done && i_avs_write && tx_hit)
      tx_ptr_q[tx_n] <= merge_be(tx_ptr_q[tx_n], i_avs_writedata, i_avs_byteenable);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_tx_desc_base  <= '0;
      o_tx_desc_count <= '0;
    end
    else
    begin
      for (int n = 0; n < idc_pkg::NUM_CTX; n++)
      begin
        o_tx_desc_base[n]  <= tx_ptr_q[n][31:4];
        o_tx_desc_count[n] <= tx_ptr_q[n][3:0];
      end
    end
  end

  // ===========================================================
  // receive contexts
  logic [14:0]      now_cycle;
  logic [7:0][31:0] rx_ctrl;
  logic [7:0][4:0]  rx_mode;
  logic [7:0]       rx_start;

  assign now_cycle = {i_seconds_count, i_cycle_number};

  for (genvar g = 0; g < 8; g++)
  begin : g_ctx
    idc_ctx_if u_if ();

    assign u_if.set_we    = done & i_avs_write & set_hit & (set_n == 3'(g));
    assign u_if.clr_we    = done & i_avs_write & clr_hit & (clr_n == 3'(g));
    assign u_if.wdata     = rx_wd;
    assign u_if.fetch     = i_rx_fetch[g];
    assign u_if.fatal     = i_rx_fatal[g];
    assign u_if.active    = i_rx_active[g];
    assign u_if.status_we = i_rx_status_we[g];
    assign u_if.speed     = i_rx_speed[g];
    assign u_if.code      = i_rx_code[g];
    assign u_if.cyc_match = (i_start_cycle_value[g] == now_cycle);
    assign rx_ctrl[g]     = u_if.ctrl;
    assign rx_mode[g]     = u_if.mode;
    assign rx_start[g]    = u_if.start_ok;

    idc_rx_ctx u_ctx
    (
      .i_clk  (i_clk),
      .i_srst (i_srst),
      .bus    (u_if.ctx_mp)
    );
  end

  // mode bits other than bit 2 fan out to the packet engine, which gives them their meaning
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_rx_pack_buffer_mode   <= 8'h00;
      o_rx_keep_packet_header <= 8'h00;
      o_rx_all_channel_mode   <= 8'h00;
      o_rx_split_payload_mode <= 8'h00;
      o_rx_start_ok           <= 8'h00;
    end
    else
    begin
      for (int n = 0; n < idc_pkg::NUM_CTX; n++)
      begin
        o_rx_pack_buffer_mode[n]   <= rx_mode[n][4];
        o_rx_keep_packet_header[n] <= rx_mode[n][3];
        o_rx_all_channel_mode[n]   <= rx_mode[n][1];
        o_rx_split_payload_mode[n] <= rx_mode[n][0];
      end
      o_rx_start_ok <= rx_start;
    end
  end

  // ===========================================================
  // read data: set and clear addresses both show the control value
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      rdata_q <= 32'h0000_0000;
    else if (i_avs_read && wait_q)
    begin
      if (tx_hit)
        rdata_q <= tx_ptr_q[tx_n];
      else if (set_hit)
        rdata_q <= rx_ctrl[set_n];
      else if (clr_hit)
        rdata_q <= rx_ctrl[clr_n];
      else
        rdata_q <= 32'h0000_0000;
    end
  end

  assign o_avs_readdata    = rdata_q;
  assign o_avs_waitrequest = wait_q;

endmodule

`default_nettype wire

// *** bench/idc_iso_dma_regs_monitor.sv ***
// Purpose : port-level checks for the iso dma register bank
// Assumes : single clock, synchronous active-high reset
// Notes   : bound to the top module at the foot of this file
`timescale 1ns/1ps
`default_nettype none

module idc_iso_dma_regs_monitor
(
  input  wire logic            i_clk,
  input  wire logic            i_srst,
  input  wire logic [10:0]     i_avs_address,
  input  wire logic            i_avs_read,
  input  wire logic            i_avs_write,
  input  wire logic [31:0]     i_avs_writedata,
  input  wire logic [3:0]      i_avs_byteenable,
  input  wire logic [31:0]     o_avs_readdata,
  input  wire logic            o_avs_waitrequest,
  input  wire logic [7:0][27:0] o_tx_desc_base,
  input  wire logic [7:0][3:0] o_tx_desc_count,
  input  wire logic [7:0]      i_rx_fatal,
  input  wire logic [7:0]      o_rx_pack_buffer_mode,
  input  wire logic [7:0]      o_rx_keep_packet_header,
  input  wire logic [7:0]      o_rx_split_payload_mode,
  input  wire logic [7:0]      o_rx_start_ok
);
  logic wr_ok;
  logic rd_ok;
  assign wr_ok = i_avs_write & ~o_avs_waitrequest;
  assign rd_ok = i_avs_read & ~o_avs_waitrequest;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  // ==========================================================
  // assertions
  // reset must not be masked by the default disable
  property p_rst;
    disable iff (1'b0) i_srst |=> o_avs_waitrequest && o_rx_start_ok == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("reset left outputs set");
  property p_tx_count;
    wr_ok && i_avs_address == 11'h20c && i_avs_byteenable == 4'hf
      |=> ##1 o_tx_desc_count[0] == $past(i_avs_writedata[3:0], 2);
  endproperty
  a_tx_count: assert property (p_tx_count) else $error("tx count copy wrong");
  property p_tx_base;
    wr_ok && i_avs_address == 11'h27c && i_avs_byteenable == 4'hf
      |=> ##1 o_tx_desc_base[7] == $past(i_avs_writedata[31:4], 2);
  endproperty
  a_tx_base: assert property (p_tx_base) else $error("tx base copy wrong");
  property p_pack;
    wr_ok && i_avs_address == 11'h400 && i_avs_byteenable[3] && i_avs_writedata[31]
      |=> ##1 o_rx_pack_buffer_mode[0];
  endproperty
  a_pack: assert property (p_pack) else $error("pack mode not set");
  property p_keep;
    wr_ok && i_avs_address == 11'h404 && i_avs_byteenable[3] && i_avs_writedata[30]
      |=> ##1 !o_rx_keep_packet_header[0];
  endproperty
  a_keep: assert property (p_keep) else $error("header mode not cleared");
  property p_split;
    wr_ok && i_avs_address == 11'h440 && i_avs_byteenable[3] && i_avs_writedata[27]
      |=> ##1 o_rx_split_payload_mode[2];
  endproperty
  a_split: assert property (p_split) else $error("split mode not set");
  property p_fatal;
    i_rx_fatal[4] |-> ##[1:4] !o_rx_start_ok[4];
  endproperty
  a_fatal: assert property (p_fatal) else $error("start kept after fatal");
  property p_rsvd;
    rd_ok && i_avs_address[10] && i_avs_address[4:3] == 2'h0 && i_avs_address[1:0] == 2'h0
      |-> (o_avs_readdata & 32'h07ff_6300) == 32'h0000_0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
endmodule

bind idc_iso_dma_regs idc_iso_dma_regs_monitor u_mon (.i_clk, .i_srst, .i_avs_address, .i_avs_read,
  .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .o_tx_desc_base,
  .o_tx_desc_count, .i_rx_fatal, .o_rx_pack_buffer_mode, .o_rx_keep_packet_header,
  .o_rx_split_payload_mode, .o_rx_start_ok);

`default_nettype wire

// *** bench/idc_iso_dma_regs_tb.sv ***
// Purpose : self-checking bench for the iso dma register bank
// Assumes : 40 MHz clock, Avalon-MM master in the bench
// Notes   : table of write/readback rows, then hand-written cases
`timescale 1ns/1ps
`default_nettype none

module idc_iso_dma_regs_tb;
  typedef struct packed {logic [10:0] a; logic [31:0] d; logic [3:0] be; logic [31:0] e;} idc_row_s;
  logic                i_clk, i_srst, i_avs_read, i_avs_write, o_avs_waitrequest;
  logic [10:0]         i_avs_address;
  logic [31:0]         i_avs_writedata, o_avs_readdata, rd;
  logic [3:0]          i_avs_byteenable;
  logic [7:0][27:0]    o_tx_desc_base;
  logic [7:0][3:0]     o_tx_desc_count;
  logic [7:0]          i_rx_fetch, i_rx_fatal, i_rx_active, i_rx_status_we;
  logic [7:0][2:0]     i_rx_speed;
  logic [7:0][4:0]     i_rx_code;
  logic [7:0][14:0]    i_start_cycle_value;
  logic [1:0]          i_seconds_count;
  logic [12:0]         i_cycle_number;
  logic [7:0]          o_rx_pack_buffer_mode, o_rx_keep_packet_header, o_rx_all_channel_mode;
  logic [7:0]          o_rx_split_payload_mode, o_rx_start_ok;
  int                  mismatches = 0;
  int                  cmp_count = 0;
  // unmapped places and two partial lane writes sit among the rows
  localparam idc_row_s ROWS [8] = '{
    '{11'h20c, 32'ha5a5a5a3, 4'hf, 32'ha5a5a5a3}, '{11'h27c, 32'h1234567f, 4'hf, 32'h1234567f},
    '{11'h22c, 32'hffffffff, 4'h1, 32'h000000ff}, '{11'h400, 32'hd000f0ff, 4'hf, 32'hd0009000},
    '{11'h404, 32'hffffffff, 4'hf, 32'h00000000}, '{11'h4a0, 32'hffffffff, 4'h7, 32'h00009000},
    '{11'h100, 32'hffffffff, 4'hf, 32'h00000000}, '{11'h40c, 32'hffffffff, 4'hf, 32'h00000000}};

  idc_iso_dma_regs i_dut (.i_clk, .i_srst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .o_tx_desc_base, .o_tx_desc_count,
    .i_rx_fetch, .i_rx_fatal, .i_rx_active, .i_rx_status_we, .i_rx_speed, .i_rx_code,
    .i_start_cycle_value, .i_seconds_count, .i_cycle_number, .o_rx_pack_buffer_mode,
    .o_rx_keep_packet_header, .o_rx_all_channel_mode, .o_rx_split_payload_mode, .o_rx_start_ok);

  // ==========================================================
  // tasks
  task automatic close_out;
    if (mismatches == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // bounded wait for waitrequest low; no latency is assumed
  task automatic ack;
    int n;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (o_avs_waitrequest !== 1'b0 && n < 64);
    if (o_avs_waitrequest !== 1'b0)
    begin
      mismatches++;
      $display("Error %0t: bus never answered", $time);
      close_out();
    end
  endtask

  task automatic av_wr(input logic [10:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge i_clk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_byteenable <= be;
    i_avs_write <= 1'b1;
    ack();
    i_avs_write <= 1'b0;
  endtask

  task automatic av_rd(input logic [10:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_avs_address <= a;
    i_avs_read <= 1'b1;
    ack();
    d = o_avs_readdata;
    i_avs_read <= 1'b0;
  endtask

  // ==========================================================
  // clock, watchdog and main sequence
  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  initial
  begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    close_out();
  end

  initial
  begin
    {i_avs_read, i_avs_write, i_avs_address, i_avs_writedata, i_avs_byteenable} = '0;
    {i_rx_fetch, i_rx_fatal, i_rx_active, i_rx_status_we, i_rx_speed, i_rx_code} = '0;
    i_start_cycle_value = '0;
    i_start_cycle_value[7] = 15'h1234;
    i_seconds_count = 2'h0;
    i_cycle_number = 13'h0000;
    i_srst = 1'b1;
    repeat (8) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    chk(o_avs_waitrequest, 32'h1);
    av_rd(11'h23c, rd);
    chk(rd, 32'h0);
    foreach (ROWS[i])
    begin
      av_wr(ROWS[i].a, ROWS[i].d, ROWS[i].be);
      av_rd(ROWS[i].a, rd);
      chk(rd, ROWS[i].e);
    end
    chk({o_tx_desc_base[0], o_tx_desc_count[0]}, 32'ha5a5a5a3);
    chk({o_tx_desc_base[7], o_tx_desc_count[7]}, 32'h1234567f);
    chk({o_tx_desc_base[2], o_tx_desc_count[2]}, 32'h000000ff);
    av_wr(11'h420, 32'hd0000000, 4'hf);
    repeat (3) @(posedge i_clk);
    chk({o_rx_pack_buffer_mode[1], o_rx_keep_packet_header[1], o_rx_all_channel_mode[1],
         o_rx_split_payload_mode[1]}, 32'he);
    av_wr(11'h424, 32'hf8000000, 4'hf);
    av_wr(11'h440, 32'h08000000, 4'hf);
    repeat (3) @(posedge i_clk);
    chk({o_rx_pack_buffer_mode[2:1], o_rx_split_payload_mode[2:1]}, 32'h2);
    av_wr(11'h480, 32'h00009000, 4'hf);
    @(posedge i_clk) i_rx_fetch <= 8'h10;
    @(posedge i_clk) i_rx_fetch <= 8'h00;
    av_rd(11'h484, rd);
    chk(rd, 32'h00008000);
    @(posedge i_clk) i_rx_fatal <= 8'h10;
    @(posedge i_clk) i_rx_fatal <= 8'h00;
    av_rd(11'h480, rd);
    chk(rd, 32'h00008800);
    av_wr(11'h484, 32'h00008000, 4'hf);
    av_rd(11'h480, rd);
    chk(rd, 32'h0);
    av_wr(11'h480, 32'h20000000, 4'hf);
    av_rd(11'h480, rd);
    chk(rd, 32'h20000000);
    @(posedge i_clk) i_rx_active <= 8'h10;
    // one more edge: active shows first, the hardware clear of bit 29 follows a cycle later
    @(posedge i_clk);
    av_rd(11'h480, rd);
    chk(rd, 32'h00000400);
    for (int s = 0; s < 3; s++)
    begin
      @(posedge i_clk);
      i_rx_speed[6] <= s[2:0];
      i_rx_code[6] <= 5'h15 + s[4:0];
      i_rx_status_we <= 8'h40;
      @(posedge i_clk) i_rx_status_we <= 8'h00;
      av_rd(11'h4c0, rd);
      chk(rd, {24'h0, s[2:0], 5'h15 + s[4:0]});
    end
    // start must wait for the cycle match, then follow it
    av_wr(11'h4e0, 32'h20008000, 4'hf);
    repeat (4) @(posedge i_clk);
    chk(o_rx_start_ok[7], 32'h0);
    i_cycle_number <= 13'h1234;
    repeat (4) @(posedge i_clk);
    chk(o_rx_start_ok[7], 32'h1);
    // mid-run reset must raise waitrequest and bring start_ok, the context 7 tx pointer and its outputs, and the context 7 rx control back to zero
    @(posedge i_clk) i_srst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    chk(o_avs_waitrequest, 32'h1);
    chk(o_rx_start_ok, 32'h0);
    chk({o_tx_desc_base[7], o_tx_desc_count[7]}, 32'h0);
    av_rd(11'h27c, rd);
    chk(rd, 32'h0);
    av_rd(11'h4e0, rd);
    chk(rd, 32'h0);
    close_out();
  end
endmodule

`default_nettype wire
